// ===== src/acg_pkg.sv
// Package of constants and types for the axis command gate
package acg_pkg;
   // Timing
   localparam int           CLK_HZ      = 40_000_000;
   localparam int           CLK_NS      = 1_000_000_000 / CLK_HZ;
   localparam int           SCAN_NS     = 100_000;
   localparam int           SCAN_CYC    = SCAN_NS / CLK_NS;
   localparam logic [11:0]  SCAN_LAST   = 12'(SCAN_CYC - 1);

   // Register byte offsets
   localparam logic [7:0]   OFS_CTRL    = 8'h00;
   localparam logic [7:0]   OFS_CMD     = 8'h04;
   localparam logic [7:0]   OFS_TARGET  = 8'h08;
   localparam logic [7:0]   OFS_SPEED   = 8'h0C;
   localparam logic [7:0]   OFS_ACCDEC  = 8'h10;
   localparam logic [7:0]   OFS_SRC     = 8'h14;
   localparam logic [7:0]   OFS_FLAGS   = 8'h18;
   localparam logic [7:0]   OFS_OPERR   = 8'h1C;
   localparam logic [7:0]   OFS_AXERR   = 8'h20;
   localparam logic [7:0]   OFS_IRQSTAT = 8'h24;
   localparam logic [7:0]   OFS_IRQMASK = 8'h28;
   localparam logic [7:0]   OFS_SPDLIM  = 8'h2C;
   localparam logic [7:0]   OFS_AXSTATE = 8'h30;

   // Command bit positions in CMD and the CTRL mode fields
   localparam int           NCMD        = 9;
   localparam int           CMD_TABLE   = 0;
   localparam int           CMD_DIRECT  = 1;
   localparam int           CMD_JOINT   = 2;
   localparam int           CMD_HOME    = 3;
   localparam int           CMD_JOG     = 4;
   localparam int           CMD_ABSRST  = 5;
   localparam int           CMD_HALT    = 6;
   localparam int           CMD_SPDCHG  = 7;
   localparam int           CMD_TGTCHG  = 8;
   localparam int           NSTART      = 6;

   // CTRL fields
   localparam int           CTRL_EN     = 0;
   localparam int           CTRL_PULSE  = 8;
   localparam int           CTRL_SUB    = 20;

   // FLAGS bits
   localparam int           FLG_OPERR    = 3;

   // IRQ status bits
   localparam int           NIRQ        = 4;

   // Operand source codes
   localparam logic [1:0]   SRC_DEVICE  = 2'h1;

   // Error codes
   localparam logic [15:0]  ERR_OPERAND = 16'h1005;
   localparam logic [15:0]  ERR_NOTUSED = 16'h1014;
   localparam logic [15:0]  ERR_HALTON  = 16'h044E;

   // Axis state codes
   localparam logic [7:0]   ST_STANDBY  = 8'h00;
   localparam logic [7:0]   ST_STOPPED  = 8'h01;
   localparam logic [7:0]   ST_ERROR    = 8'hFF;
   localparam logic [7:0]   ST_DEC_HALT = 8'h07;
   localparam logic [7:0]   ST_DEC_JOG  = 8'h08;
   localparam logic [7:0]   ST_ANALYZE  = 8'h0B;

   // Limits and reset values
   localparam logic [31:0]  SPEED_MAX   = 32'h00030D40;
   localparam logic [14:0]  TIME_MASK   = 15'h7FFF;
   localparam logic [31:0]  SPDLIM_RST  = 32'h00030D40;
   localparam logic [31:0]  CTRL_RST    = 32'h00000000;

   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} acg_bus_t;
endpackage

// ===== src/acg_edge_gate.sv
// Per-command edge or level execution gate, evaluated once a scan
`timescale 1ns/1ps
module acg_edge_gate (
   input  wire logic                     clk,        // System clock
   input  wire logic                     nrst,       // Async reset, active low
   input  wire logic                     scanTick,   // One pulse per scan
   input  wire logic [acg_pkg::NCMD-1:0] level,      // Command condition levels
   input  wire logic [acg_pkg::NCMD-1:0] pulseMode,  // 1: edge-executed variant
   input  wire logic [acg_pkg::NCMD-1:0] subMode,    // 1: lives in interrupt/subroutine
   output logic      [acg_pkg::NCMD-1:0] fire        // Execute this scan
);
   logic [acg_pkg::NCMD-1:0] prev_reg;
   logic [acg_pkg::NCMD-1:0] prev_next;
   logic [acg_pkg::NCMD-1:0] seen_reg;
   logic [acg_pkg::NCMD-1:0] seen_next;

   genvar i;
   for (i = 0; i < acg_pkg::NCMD; i++) begin : g_cmd
      logic edgeHit;
      always_comb begin
         edgeHit = scanTick & level[i] & ~prev_reg[i];
         prev_next[i] = scanTick ? level[i] : prev_reg[i];
         seen_next[i] = seen_reg[i] | (edgeHit & pulseMode[i] & subMode[i]);
         if (pulseMode[i]) begin
            fire[i] = edgeHit & (~subMode[i] | seen_reg[i]);
         end else begin
            fire[i] = scanTick & level[i];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_reg <= '0;
         seen_reg <= '0;
      end else begin
         prev_reg <= prev_next;
         seen_reg <= seen_next;
      end
   end
endmodule // acg_edge_gate

// ===== src/acg_axis_command_gate.sv
// Axis command gate with AHB-Lite register access
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

// How it works
// - Target change loads the signed 32-bit pulse value as the new target.
// - Halt, speed and target changes are dropped in states 0, 1, -1, 7, 8, 11.
// - State codes: standby 0, stopped 1, error -1, decel 7 and 8, analyzing 11.
// - Target change with unusable operand source records operation error 4101.
// - Any instruction on an axis not enabled records operation error 4116.
// - Operation errors set the error flag and store the error code word.
// - Start requests are ignored while the start request flag is set.
// - Once the start request flag clears, starts are taken despite in-operation flag.
// - Jog and halt are evaluated every scan, even with command off.
// - Pulse variants execute only on a rising command edge.
// - Pulse variants in interrupt or subroutine skip their first rising edge.
// - Start while halt is active is refused with axis error 1102.
// - Deceleration stop from halt leaves positioning done flag cleared.
// - Speeds outside 0 to 200000 are replaced by the speed limit.
// - Speed change carries 0 to 32767 ms accel and decel times plus speed.
// - Halt is ignored while absolute position restoration runs.
module acg_axis_command_gate (
   input  wire logic        clk,            // 40 MHz system clock
   input  wire logic        nrst,           // Async reset, active low
   input  wire logic        hsel,           // AHB slave select
   input  wire logic [31:0] haddr,          // AHB address
   input  wire logic [1:0]  htrans,         // AHB transfer type
   input  wire logic        hwrite,         // AHB write
   input  wire logic [2:0]  hsize,          // AHB size
   input  wire logic [31:0] hwdata,         // AHB write data
   input  wire logic        hready,         // AHB bus ready
   output logic      [31:0] hrdata,         // AHB read data
   output logic             hreadyout,      // AHB slave ready
   output logic             hresp,          // AHB response, always OKAY
   output logic             irq,            // Level interrupt
   input  wire logic [7:0]  axisState,      // Axis state code from engine
   input  wire logic        engineTake,     // Engine took the start, pulse
   input  wire logic        engineBusy,     // Engine moving, level
   input  wire logic        motionDone,     // Motion or decel stop finished, pulse
   input  wire logic        absRestoreBusy, // Absolute restoration in progress
   output logic             launchPulse,    // Start accepted, pulse
   output logic      [2:0]  launchKind,     // Index of accepted start command
   output logic             haltOut,        // Halt request to engine, level
   output logic             jogHold,        // Jog command level, per scan
   output logic             speedChgPulse,  // Speed change, pulse
   output logic             targetChgPulse, // Target change, pulse
   output logic      [31:0] targetPos,      // Active target position
   output logic      [31:0] newSpeed,       // Speed to apply
   output logic      [14:0] accTime,        // Accel time, ms
   output logic      [14:0] decTime         // Decel time, ms
);
   acg_pkg::acg_bus_t busSt_reg, busSt_next;
   logic [7:0]  addr_reg, addr_next;
   logic [31:0] rdata_reg, rdata_next;

   logic [31:0] ctrl_reg, ctrl_next;
   logic [acg_pkg::NCMD-1:0] cmd_reg, cmd_next;
   logic [31:0] tgtVal_reg, tgtVal_next;
   logic [31:0] spdVal_reg, spdVal_next;
   logic [31:0] accdec_reg, accdec_next;
   logic [3:0]  src_reg, src_next;
   logic [31:0] spdLim_reg, spdLim_next;
   logic [acg_pkg::NIRQ-1:0] irqStat_reg, irqStat_next;
   logic [acg_pkg::NIRQ-1:0] irqMask_reg, irqMask_next;

   logic [11:0] scanCnt_reg, scanCnt_next;
   logic        scanTick_reg, scanTick_next;
   logic        startReq_reg, startReq_next;
   logic        inOp_reg, inOp_next;
   logic        done_reg, done_next;
   logic        opErr_reg, opErr_next;
   logic [15:0] opCode_reg, opCode_next;
   logic [15:0] axCode_reg, axCode_next;
   logic        haltDec_reg, haltDec_next;
   logic        launch_reg, launch_next;
   logic [2:0]  kind_reg, kind_next;
   logic        halt_reg, halt_next;
   logic        jog_reg, jog_next;
   logic        spdPulse_reg, spdPulse_next;
   logic        tgtPulse_reg, tgtPulse_next;
   logic [31:0] target_reg, target_next;
   logic [31:0] speed_reg, speed_next;
   logic [14:0] acc_reg, acc_next;
   logic [14:0] dec_reg, dec_next;
   logic        irq_reg, irq_next;

   logic [acg_pkg::NCMD-1:0] fire;
   logic addrPhase;
   logic wrEn;
   logic [31:0] flags;

   acg_edge_gate u_edge (
      .clk       (clk),
      .nrst      (nrst),
      .scanTick  (scanTick_reg),
      .level     (cmd_reg),
      .pulseMode (ctrl_reg[acg_pkg::CTRL_PULSE +: acg_pkg::NCMD]),
      .subMode   (ctrl_reg[acg_pkg::CTRL_SUB +: acg_pkg::NCMD]),
      .fire      (fire)
   );

   assign addrPhase = hsel & hready & htrans[1];
   assign wrEn      = (busSt_reg == acg_pkg::BUS_WRITE);
   assign flags     = {27'h0000000, haltDec_reg, opErr_reg, done_reg, inOp_reg, startReq_reg};

   // Bus slave and software registers
   always_comb begin
      busSt_next   = acg_pkg::BUS_IDLE;
      addr_next    = addr_reg;
      rdata_next   = 32'h00000000;
      ctrl_next    = ctrl_reg;
      cmd_next     = cmd_reg;
      tgtVal_next  = tgtVal_reg;
      spdVal_next  = spdVal_reg;
      accdec_next  = accdec_reg;
      src_next     = src_reg;
      spdLim_next  = spdLim_reg;
      irqMask_next = irqMask_reg;
      if (addrPhase) begin
         addr_next  = haddr[7:0];
         busSt_next = hwrite ? acg_pkg::BUS_WRITE : acg_pkg::BUS_READ;
         unique case (haddr[7:0])
            acg_pkg::OFS_CTRL:    rdata_next = ctrl_reg;
            acg_pkg::OFS_CMD:     rdata_next = {23'h000000, cmd_reg};
            acg_pkg::OFS_TARGET:  rdata_next = tgtVal_reg;
            acg_pkg::OFS_SPEED:   rdata_next = spdVal_reg;
            acg_pkg::OFS_ACCDEC:  rdata_next = accdec_reg;
            acg_pkg::OFS_SRC:     rdata_next = {28'h0000000, src_reg};
            acg_pkg::OFS_FLAGS:   rdata_next = flags;
            acg_pkg::OFS_OPERR:   rdata_next = {16'h0000, opCode_reg};
            acg_pkg::OFS_AXERR:   rdata_next = {16'h0000, axCode_reg};
            acg_pkg::OFS_IRQSTAT: rdata_next = {28'h0000000, irqStat_reg};
            acg_pkg::OFS_IRQMASK: rdata_next = {28'h0000000, irqMask_reg};
            acg_pkg::OFS_SPDLIM:  rdata_next = spdLim_reg;
            acg_pkg::OFS_AXSTATE: rdata_next = {24'h000000, axisState};
            default:              rdata_next = 32'h00000000;
         endcase
      end
      if (wrEn) begin
         unique case (addr_reg)
            acg_pkg::OFS_CTRL:    ctrl_next = hwdata;
            acg_pkg::OFS_CMD:     cmd_next = hwdata[acg_pkg::NCMD-1:0];
            acg_pkg::OFS_TARGET:  tgtVal_next = hwdata;
            acg_pkg::OFS_SPEED:   spdVal_next = hwdata;
            acg_pkg::OFS_ACCDEC:  accdec_next = hwdata;
            acg_pkg::OFS_SRC:     src_next = hwdata[3:0];
            acg_pkg::OFS_IRQMASK: irqMask_next = hwdata[acg_pkg::NIRQ-1:0];
            acg_pkg::OFS_SPDLIM:  spdLim_next = hwdata;
            default:              ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busSt_reg   <= acg_pkg::BUS_IDLE;
         addr_reg    <= 8'h00;
         rdata_reg   <= 32'h00000000;
         ctrl_reg    <= acg_pkg::CTRL_RST;
         cmd_reg     <= '0;
         tgtVal_reg  <= 32'h00000000;
         spdVal_reg  <= 32'h00000000;
         accdec_reg  <= 32'h00000000;
         src_reg     <= 4'h0;
         spdLim_reg  <= acg_pkg::SPDLIM_RST;
         irqMask_reg <= '0;
      end else begin
         busSt_reg   <= busSt_next;
         addr_reg    <= addr_next;
         rdata_reg   <= rdata_next;
         ctrl_reg    <= ctrl_next;
         cmd_reg     <= cmd_next;
         tgtVal_reg  <= tgtVal_next;
         spdVal_reg  <= spdVal_next;
         accdec_reg  <= accdec_next;
         src_reg     <= src_next;
         spdLim_reg  <= spdLim_next;
         irqMask_reg <= irqMask_next;
      end
   end

   // Scan evaluation and axis flags
   always_comb begin
      logic enabled;
      logic stateIdle;
      logic [acg_pkg::NSTART-1:0] starts;
      logic errOp;
      logic errAx;
      logic ignoredEv;
      logic doneEv;
      logic [acg_pkg::NIRQ-1:0] clr;
      enabled   = ctrl_reg[acg_pkg::CTRL_EN];
      stateIdle = (axisState == acg_pkg::ST_STANDBY) || (axisState == acg_pkg::ST_STOPPED)
               || (axisState == acg_pkg::ST_ERROR) || (axisState == acg_pkg::ST_DEC_HALT)
               || (axisState == acg_pkg::ST_DEC_JOG)
               || (axisState == acg_pkg::ST_ANALYZE);
      starts    = fire[acg_pkg::NSTART-1:0];
      errOp     = 1'b0;
      errAx     = 1'b0;
      ignoredEv = 1'b0;
      doneEv    = 1'b0;
      clr       = '0;
      scanCnt_next  = (scanCnt_reg == acg_pkg::SCAN_LAST) ? 12'h000 : scanCnt_reg + 12'h001;
      scanTick_next = (scanCnt_reg == acg_pkg::SCAN_LAST);
      startReq_next = startReq_reg & ~engineTake;
      inOp_next     = inOp_reg & (engineBusy | startReq_reg);
      done_next     = done_reg;
      opErr_next    = opErr_reg;
      opCode_next   = opCode_reg;
      axCode_next   = axCode_reg;
      haltDec_next  = haltDec_reg;
      launch_next   = 1'b0;
      kind_next     = kind_reg;
      halt_next     = halt_reg;
      jog_next      = jog_reg;
      spdPulse_next = 1'b0;
      tgtPulse_next = 1'b0;
      target_next   = target_reg;
      speed_next    = speed_reg;
      acc_next      = acc_reg;
      dec_next      = dec_reg;
      if (motionDone) begin
         done_next    = ~haltDec_reg;
         doneEv       = ~haltDec_reg;
         haltDec_next = 1'b0;
      end
      if (scanTick_reg) begin
         jog_next  = cmd_reg[acg_pkg::CMD_JOG];
         halt_next = 1'b0;
         if (!enabled) begin
            errOp       = 1'b1;
            opCode_next = acg_pkg::ERR_NOTUSED;
         end else begin
            if (fire[acg_pkg::CMD_HALT] && !stateIdle && !absRestoreBusy) begin
               halt_next    = 1'b1;
               haltDec_next = 1'b1;
            end
            if (|starts) begin
               if (startReq_reg) begin
                  ignoredEv = 1'b1;
               end else if (cmd_reg[acg_pkg::CMD_HALT]) begin
                  errAx       = 1'b1;
                  axCode_next = acg_pkg::ERR_HALTON;
               end else begin
                  // Lowest index wins if several start in one scan
                  for (int k = acg_pkg::NSTART - 1; k >= 0; k--) begin
                     if (starts[k]) begin
                        kind_next = 3'(k);
                     end
                  end
                  launch_next   = 1'b1;
                  startReq_next = 1'b1;
                  inOp_next     = 1'b1;
                  done_next     = 1'b0;
                  haltDec_next  = 1'b0;
               end
            end
            if (fire[acg_pkg::CMD_SPDCHG]) begin
               if (src_reg[1:0] > acg_pkg::SRC_DEVICE) begin
                  errOp       = 1'b1;
                  opCode_next = acg_pkg::ERR_OPERAND;
               end else if (!stateIdle) begin
                  spdPulse_next = 1'b1;
                  acc_next      = accdec_reg[14:0] & acg_pkg::TIME_MASK;
                  dec_next      = accdec_reg[30:16] & acg_pkg::TIME_MASK;
                  speed_next    = (spdVal_reg > acg_pkg::SPEED_MAX) ? spdLim_reg
                                                                    : spdVal_reg;
               end
            end
            if (fire[acg_pkg::CMD_DIRECT] || fire[acg_pkg::CMD_JOG]) begin
               speed_next = (spdVal_reg > acg_pkg::SPEED_MAX) ? spdLim_reg : spdVal_reg;
            end
            if (fire[acg_pkg::CMD_TGTCHG]) begin
               if (src_reg[3:2] > acg_pkg::SRC_DEVICE) begin
                  errOp       = 1'b1;
                  opCode_next = acg_pkg::ERR_OPERAND;
               end else if (!stateIdle) begin
                  tgtPulse_next = 1'b1;
                  target_next   = tgtVal_reg;
               end
            end
         end
      end
      // Flag clear by writing one; a set in the same cycle wins
      if (wrEn && addr_reg == acg_pkg::OFS_IRQSTAT) begin
         clr = hwdata[acg_pkg::NIRQ-1:0];
      end
      if (wrEn && addr_reg == acg_pkg::OFS_FLAGS && hwdata[acg_pkg::FLG_OPERR]) begin
         opErr_next = 1'b0;
      end
      if (errOp) begin
         opErr_next = 1'b1;
      end
      irqStat_next = (irqStat_reg & ~clr) | {ignoredEv, doneEv, errAx, errOp};
      irq_next     = |(irqStat_next & irqMask_next);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scanCnt_reg  <= 12'h000;
         scanTick_reg <= 1'b0;
         startReq_reg <= 1'b0;
         inOp_reg     <= 1'b0;
         done_reg     <= 1'b0;
         opErr_reg    <= 1'b0;
         opCode_reg   <= 16'h0000;
         axCode_reg   <= 16'h0000;
         haltDec_reg  <= 1'b0;
         launch_reg   <= 1'b0;
         kind_reg     <= 3'h0;
         halt_reg     <= 1'b0;
         jog_reg      <= 1'b0;
         spdPulse_reg <= 1'b0;
         tgtPulse_reg <= 1'b0;
         target_reg   <= 32'h00000000;
         speed_reg    <= 32'h00000000;
         acc_reg      <= 15'h0000;
         dec_reg      <= 15'h0000;
         irqStat_reg  <= '0;
         irq_reg      <= 1'b0;
      end else begin
         scanCnt_reg  <= scanCnt_next;
         scanTick_reg <= scanTick_next;
         startReq_reg <= startReq_next;
         inOp_reg     <= inOp_next;
         done_reg     <= done_next;
         opErr_reg    <= opErr_next;
         opCode_reg   <= opCode_next;
         axCode_reg   <= axCode_next;
         haltDec_reg  <= haltDec_next;
         launch_reg   <= launch_next;
         kind_reg     <= kind_next;
         halt_reg     <= halt_next;
         jog_reg      <= jog_next;
         spdPulse_reg <= spdPulse_next;
         tgtPulse_reg <= tgtPulse_next;
         target_reg   <= target_next;
         speed_reg    <= speed_next;
         acc_reg      <= acc_next;
         dec_reg      <= dec_next;
         irqStat_reg  <= irqStat_next;
         irq_reg      <= irq_next;
      end
   end

   assign hrdata         = rdata_reg;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign irq            = irq_reg;
   assign launchPulse    = launch_reg;
   assign launchKind     = kind_reg;
   assign haltOut        = halt_reg;
   assign jogHold        = jog_reg;
   assign speedChgPulse  = spdPulse_reg;
   assign targetChgPulse = tgtPulse_reg;
   assign targetPos      = target_reg;
   assign newSpeed       = speed_reg;
   assign accTime        = acc_reg;
   assign decTime        = dec_reg;
endmodule // acg_axis_command_gate

// ===== sim/acg_gate_checker.sv
// Port assertions for the axis command gate
`timescale 1ns/1ps
module acg_gate_checker (
   input wire logic        clk,            // Clock
   input wire logic        nrst,           // Reset, active low
   input wire logic        hreadyout,      // Bus ready
   input wire logic        hresp,          // Bus response
   input wire logic [7:0]  axisState,      // Axis state code
   input wire logic        absRestoreBusy, // Restoration running
   input wire logic        launchPulse,    // Start accepted
   input wire logic        haltOut,        // Halt request
   input wire logic        speedChgPulse,  // Speed change
   input wire logic        targetChgPulse, // Target change
   input wire logic [31:0] targetPos       // Active target
);
   logic idleReg;
   // State the gate saw one cycle earlier
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) idleReg <= 1'b1;
      else idleReg <= axisState inside {8'h00, 8'h01, 8'hFF, 8'h07, 8'h08, 8'h0B};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_tgt_hold; !targetChgPulse |-> $stable(targetPos); endproperty
   property p_tgt_idle; targetChgPulse |-> !idleReg; endproperty
   property p_spd_idle; speedChgPulse |-> !idleReg; endproperty
   property p_halt_idle; $rose(haltOut) |-> !idleReg; endproperty
   property p_halt_abs; $rose(haltOut) |-> !$past(absRestoreBusy); endproperty
   property p_halt_stand; $rose(haltOut) |=> haltOut [*8]; endproperty
   property p_launch_once; launchPulse |=> !launchPulse [*8]; endproperty
   property p_bus_ok; hreadyout && !hresp; endproperty
   a_tgt_hold: assert property (p_tgt_hold)
      else $error("target moved");
   a_tgt_idle: assert property (p_tgt_idle)
      else $error("target in idle");
   a_spd_idle: assert property (p_spd_idle)
      else $error("speed in idle");
   a_halt_idle: assert property (p_halt_idle)
      else $error("halt in idle");
   a_halt_abs: assert property (p_halt_abs)
      else $error("halt in restore");
   a_halt_stand: assert property (p_halt_stand)
      else $error("halt short");
   a_launch_once: assert property (p_launch_once)
      else $error("launch repeated");
   a_bus_ok: assert property (p_bus_ok)
      else $error("bus not okay");
   c_launch: cover property (launchPulse);
   c_target: cover property (targetChgPulse);
   c_halt: cover property ($rose(haltOut));
endmodule // acg_gate_checker
bind acg_axis_command_gate acg_gate_checker chk_u (.clk, .nrst, .hreadyout, .hresp,
   .axisState, .absRestoreBusy, .launchPulse, .haltOut, .speedChgPulse, .targetChgPulse,
   .targetPos);

// ===== sim/acg_engine_model.sv
// Motion engine model facing the command gate
`timescale 1ns/1ps
module acg_engine_model (
   input wire logic       clk,            // Clock
   input wire logic       nrst,           // Reset, active low
   input wire logic [7:0] stateSel,       // State code to present
   input wire logic       stall,          // Withhold starts, restore busy
   input wire logic       launchPulse,    // Start from gate
   output logic     [7:0] axisState,      // State code
   output logic           engineTake,     // Start taken
   output logic           engineBusy,     // Moving
   output logic           motionDone,     // Motion finished
   output logic           absRestoreBusy  // Restoration running
);
   logic        pending;
   logic [13:0] runCnt;
   assign axisState = stateSel;
   assign absRestoreBusy = stall;
   assign engineBusy = runCnt != 14'h0;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending <= 1'b0;
         engineTake <= 1'b0;
         motionDone <= 1'b0;
         runCnt <= 14'h0;
      end else begin
         engineTake <= pending && !stall;
         pending <= (pending && stall) || launchPulse;
         motionDone <= runCnt == 14'h1;
         // Busy past the next scan tick
         if (pending && !stall) runCnt <= 14'h1770;
         else if (engineBusy) runCnt <= runCnt - 14'h1;
      end
   end
endmodule // acg_engine_model

// ===== sim/acg_axis_command_gate_test.sv
// Self-checking testbench for the axis command gate
`timescale 1ns/1ps
module acg_axis_command_gate_test;
   typedef struct {logic [7:0] st; logic [31:0] val; logic take;} acg_row_t;
   acg_row_t rows[8] = '{'{8'h02, 32'h80000000, 1'b1}, '{8'h00, 32'h00000005, 1'b0},
      '{8'h01, 32'h00000006, 1'b0}, '{8'hFF, 32'h00000007, 1'b0},
      '{8'h07, 32'h00000008, 1'b0}, '{8'h08, 32'h00000009, 1'b0},
      '{8'h0B, 32'h0000000A, 1'b0}, '{8'h02, 32'h7FFFFFFF, 1'b1}};
   logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, stall = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, targetPos, newSpeed, rd, expTgt;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 0, launchKind;
   logic [7:0]  stateSel = 0, axisState;
   logic [14:0] accTime, decTime;
   logic        hreadyout, hresp, irq, engineTake, engineBusy, motionDone, absRestoreBusy;
   logic        launchPulse, haltOut, jogHold, speedChgPulse, targetChgPulse;
   int          numErrors = 0, checksDone = 0, nLaunch = 0, nTgt = 0;
   acg_axis_command_gate dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .axisState,
      .engineTake, .engineBusy, .motionDone, .absRestoreBusy, .launchPulse, .launchKind,
      .haltOut, .jogHold, .speedChgPulse, .targetChgPulse, .targetPos, .newSpeed,
      .accTime, .decTime);
   acg_engine_model eng_u (.clk, .nrst, .stateSel, .stall, .launchPulse, .axisState,
      .engineTake, .engineBusy, .motionDone, .absRestoreBusy);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (launchPulse === 1'b1) nLaunch++;
      if (targetChgPulse === 1'b1) nTgt++;
   end
   task automatic stopTest;
      if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic scans(input int n);
      repeat (n * acg_pkg::SCAN_CYC) @(posedge clk);
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      numErrors++;
      stopTest();
   end
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus(1, acg_pkg::OFS_CTRL, 32'h1);
      bus(1, acg_pkg::OFS_CMD, 32'h1C0);
      expTgt = 0;
      foreach (rows[i]) begin
         stateSel <= rows[i].st;
         bus(1, acg_pkg::OFS_TARGET, rows[i].val);
         nTgt = 0;
         scans(1);
         if (rows[i].take) expTgt = rows[i].val;
         check("targetPos", expTgt, targetPos);
         check("target change", 32'(rows[i].take), 32'(nTgt != 0));
      end
      stall <= 1'b1;
      bus(1, acg_pkg::OFS_SRC, 32'h8);
      scans(1);
      bus(0, acg_pkg::OFS_OPERR, 0);
      check("operand error", 32'h1005, rd);
      check("target kept", 32'h7FFFFFFF, targetPos);
      check("restore halt", 0, haltOut);
      stall <= 1'b0;
      bus(1, acg_pkg::OFS_SRC, 0);
      bus(1, acg_pkg::OFS_CMD, 32'h41);
      nLaunch = 0;
      scans(1);
      bus(0, acg_pkg::OFS_AXERR, 0);
      check("halt error", 32'h044E, rd);
      check("refused", 0, nLaunch);
      bus(1, acg_pkg::OFS_CMD, 0);
      bus(1, acg_pkg::OFS_IRQMASK, 32'h2);
      repeat (2) @(posedge clk);
      check("irq raised", 1, irq);
      bus(1, acg_pkg::OFS_IRQSTAT, 32'h2);
      repeat (2) @(posedge clk);
      check("irq cleared", 0, irq);
      stall <= 1'b1;
      bus(1, acg_pkg::OFS_CMD, 32'h1);
      nLaunch = 0;
      scans(2);
      check("held", 1, nLaunch);
      bus(0, acg_pkg::OFS_FLAGS, 0);
      check("start flag", 1, rd[0]);
      stall <= 1'b0;
      scans(1);
      check("relaunch", 1, 32'(nLaunch > 1));
      bus(1, acg_pkg::OFS_CTRL, 32'h100101);
      nLaunch = 0;
      scans(2);
      check("pulse launches", 0, nLaunch);
      for (int n = 0; n < 2; n++) begin
         bus(1, acg_pkg::OFS_CMD, 0);
         scans(1);
         bus(1, acg_pkg::OFS_CMD, 32'h1);
         scans(1);
         check("edge launch", n, nLaunch);
      end
      bus(1, acg_pkg::OFS_CMD, 0);
      bus(1, acg_pkg::OFS_CTRL, 32'h100);
      bus(1, acg_pkg::OFS_FLAGS, 32'h8);
      scans(1);
      bus(0, acg_pkg::OFS_OPERR, 0);
      check("disabled error", 32'h1014, rd);
      bus(0, acg_pkg::OFS_FLAGS, 0);
      check("error flag", 1, rd[3]);
      nrst <= 1'b0;
      @(posedge clk);
      check("targetPos reset", 0, targetPos);
      nrst <= 1'b1;
      @(posedge clk);
      bus(0, acg_pkg::OFS_SPDLIM, 0);
      check("spdlim reset", 32'h00030D40, rd);
      bus(0, acg_pkg::OFS_CTRL, 0);
      check("ctrl reset", 0, rd);
      stopTest();
   end
endmodule // acg_axis_command_gate_test
